// ### cch_consts.svh
// named constants for the carrier channel hop control block
// assumes a 20 MHz system clock and a 4 MHz crystal reference rate
`ifndef CCH_CONSTS_SVH
`define CCH_CONSTS_SVH

`define CCH_CLK_HZ     20000000
`define CCH_REF_HZ     4000000
`define CCH_REF_DIV    (`CCH_CLK_HZ / `CCH_REF_HZ)
`define CCH_LOCK_US    1500
`define CCH_HOP_MS     2000
`define CCH_LOCK_TICKS (`CCH_LOCK_US * (`CCH_REF_HZ / 1000000))
`define CCH_HOP_TICKS  (`CCH_HOP_MS * (`CCH_REF_HZ / 1000))
`define CCH_TMR_W      24
`define CCH_PAIR_W     4
`define CCH_PAIR_RST   4'hF
`define CCH_RATE_9K6   2'h2

`endif

// ### cch_pkg.sv
// types shared by the carrier channel hop control block
// assumes nothing beyond a SystemVerilog compiler
package cch_pkg;

  // carrier frequencies that a pair can hold
  typedef enum logic [2:0] {
    CCH_F1M75  = 3'h0,
    CCH_F4M50  = 3'h1,
    CCH_F5M50  = 3'h2,
    CCH_F6M00  = 3'h3,
    CCH_F6M50  = 3'h4,
    CCH_F10M50 = 3'h5,
    CCH_F13M00 = 3'h6
  } cch_freq_t;

  // effective bit rate after the per-carrier overrides
  typedef enum logic [2:0] {
    CCH_R38K4  = 3'h0,
    CCH_R57K6  = 3'h1,
    CCH_R9K6   = 3'h2,
    CCH_R19K2  = 3'h3,
    CCH_R115K2 = 3'h4
  } cch_rate_t;

  // interference hop sequence, one-hot
  typedef enum logic [3:0] {
    CCH_HOP_IDLE = 4'h1,
    CCH_HOP_NEW  = 4'h2,
    CCH_HOP_BACK = 4'h4,
    CCH_HOP_HOLD = 4'h8
  } cch_hop_t;

endpackage

// ### cch_tmr_if.sv
// handshake between the control logic and a reference-tick timer
// assumes one clock domain; tick is a one-cycle 4 MHz strobe
`timescale 1ns/1ps
interface cch_tmr_if;
  logic start;
  logic tick;
  logic busy;
  logic done;
  modport timer (input start, input tick, output busy, output done);
  modport user  (output start, output tick, input busy, input done);
endinterface

// ### cch_tick_timer.sv
// down-counter of reference ticks with a one-cycle done pulse
// assumes start and tick are synchronous to clk
`timescale 1ns/1ps
module cch_tick_timer #(
  parameter int                W    = 24,
  parameter logic [W-1:0]      LOAD = 1
) (
  input wire logic  clk,
  input wire logic  rst,
  cch_tmr_if.timer  t
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         done_reg;
  logic         last_tick;

  // a restart wins over an expiry in the same cycle
  assign last_tick = t.tick && (cnt_reg == W'(1)) && !t.start;
  assign cnt_next  = t.start ? LOAD :
                     (t.tick && cnt_reg != '0) ? cnt_reg - W'(1) : cnt_reg;
  assign t.busy    = (cnt_reg != '0);
  assign t.done    = done_reg;

  // counter and expiry pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= last_tick;
    end
  end

endmodule

// ### cch_top.sv
// carrier selection, lock wait, interference hopping and wake trigger
// assumes all inputs synchronous to the 20 MHz clk; modem supplies status
`timescale 1ns/1ps
`include "cch_consts.svh"
module cch_top
  import cch_pkg::*;
#(
  parameter int LOCK_TICKS = `CCH_LOCK_TICKS,
  parameter int HOP_TICKS  = `CCH_HOP_TICKS
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   carrier_select_in,
  input  wire logic                   carrier_select_bit,
  input  wire logic                   hop_on_noise_enable,
  input  wire logic [`CCH_PAIR_W-1:0] pair_select,
  input  wire logic [1:0]             rate_code,
  input  wire logic                   noise_detect,
  input  wire logic                   rx_byte_event,
  input  wire logic                   tx_busy,
  input  wire logic                   sleep_request,
  input  wire logic                   wake_in,
  output logic                        active_carrier_indicator,
  output logic                        sending_active_out,
  output logic                        listening_active_out,
  output logic                        interference_status,
  output logic                        carrier_ready,
  output cch_freq_t                   first_carrier,
  output cch_freq_t                   second_carrier,
  output cch_freq_t                   active_freq,
  output cch_rate_t                   bit_rate,
  output logic                        low_power,
  output logic                        wake_broadcast
);

  cch_tmr_if lock_t ();
  cch_tmr_if hop_t ();

  logic [2:0]  div_reg;
  logic        ref_tick;
  logic        sel_or;
  logic        carrier_reg, carrier_next;
  logic        flip_reg, flip_next;
  cch_hop_t    hop_reg, hop_next;
  logic        noise_reg, noise_rise;
  logic        wake_reg, wake_edge;
  logic        wake_seen_reg;
  logic [`CCH_PAIR_W-1:0] pair_reg;
  logic        carrier_change;
  logic        sleep_reg, bcast_reg, tx_reg, rx_reg;
  cch_freq_t   f0_sel, f1_sel, fa_sel;
  cch_rate_t   rate_sel;
  cch_freq_t   f0_reg, f1_reg, fa_reg;
  cch_rate_t   rate_reg;

  // 4 MHz reference strobe from the 20 MHz clock
  assign ref_tick = (div_reg == 3'(`CCH_REF_DIV - 1));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) div_reg <= 3'h0;
    else     div_reg <= ref_tick ? 3'h0 : div_reg + 3'h1;
  end

  // timers share the strobe; both count whole reference ticks
  assign lock_t.tick  = ref_tick;
  assign hop_t.tick   = ref_tick;
  assign lock_t.start = carrier_change;
  assign hop_t.start  = (hop_next != CCH_HOP_IDLE) && (hop_next != hop_reg
                        || (hop_reg == CCH_HOP_BACK && hop_t.done));

  cch_tick_timer #(.W(`CCH_TMR_W), .LOAD(`CCH_TMR_W'(LOCK_TICKS)))
    u_lock (.clk(clk), .rst(rst), .t(lock_t));
  cch_tick_timer #(.W(`CCH_TMR_W), .LOAD(`CCH_TMR_W'(HOP_TICKS)))
    u_hop (.clk(clk), .rst(rst), .t(hop_t));

  // combined selection, then the hop toggle on top of it
  assign sel_or       = carrier_select_in | carrier_select_bit;
  assign carrier_next = sel_or ^ flip_next;
  assign noise_rise   = noise_detect && !noise_reg;
  assign wake_edge    = wake_in != wake_reg;
  // a new pair also retunes the oscillator, so it needs a lock wait
  assign carrier_change = (carrier_next != carrier_reg)
                          || (pair_select != pair_reg);

  // hop sequence: a reception anywhere ends it on the current carrier
  always_comb begin
    hop_next  = hop_reg;
    flip_next = flip_reg;
    case (hop_reg)
      CCH_HOP_IDLE: begin
        if (hop_on_noise_enable && noise_rise) begin
          flip_next = !flip_reg;
          hop_next  = CCH_HOP_NEW;
        end
      end
      CCH_HOP_NEW: begin
        if (rx_byte_event) begin
          hop_next = CCH_HOP_IDLE;
        end else if (hop_t.done) begin
          flip_next = !flip_reg;
          hop_next  = CCH_HOP_BACK;
        end
      end
      CCH_HOP_BACK: begin
        if (rx_byte_event) begin
          hop_next = CCH_HOP_IDLE;
        end else if (hop_t.done && !noise_detect) begin
          flip_next = !flip_reg;
          hop_next  = CCH_HOP_HOLD;
        end
      end
      CCH_HOP_HOLD: hop_next = CCH_HOP_IDLE; // settle, then re-arm
      default:      hop_next = CCH_HOP_IDLE;
    endcase
    // dropping the enable ends the sequence on the carrier it stands on
    if (!hop_on_noise_enable) begin
      hop_next  = CCH_HOP_IDLE;
      flip_next = flip_reg;
    end
  end

  // pair table: sixteen pairs of two carriers each
  always_comb begin
    case (pair_reg)
      4'h0: begin f0_sel = CCH_F1M75;  f1_sel = CCH_F4M50;  end
      4'h1: begin f0_sel = CCH_F1M75;  f1_sel = CCH_F5M50;  end
      4'h2: begin f0_sel = CCH_F1M75;  f1_sel = CCH_F6M00;  end
      4'h3: begin f0_sel = CCH_F1M75;  f1_sel = CCH_F6M50;  end
      4'h4: begin f0_sel = CCH_F4M50;  f1_sel = CCH_F5M50;  end
      4'h5: begin f0_sel = CCH_F4M50;  f1_sel = CCH_F6M00;  end
      4'h6: begin f0_sel = CCH_F4M50;  f1_sel = CCH_F6M50;  end
      4'h7: begin f0_sel = CCH_F4M50;  f1_sel = CCH_F10M50; end
      4'h8: begin f0_sel = CCH_F10M50; f1_sel = CCH_F13M00; end
      4'h9: begin f0_sel = CCH_F5M50;  f1_sel = CCH_F10M50; end
      4'hA: begin f0_sel = CCH_F5M50;  f1_sel = CCH_F13M00; end
      4'hB: begin f0_sel = CCH_F6M00;  f1_sel = CCH_F10M50; end
      4'hC: begin f0_sel = CCH_F6M00;  f1_sel = CCH_F13M00; end
      4'hD: begin f0_sel = CCH_F6M50;  f1_sel = CCH_F10M50; end
      4'hE: begin f0_sel = CCH_F6M50;  f1_sel = CCH_F13M00; end
      default: begin f0_sel = CCH_F5M50; f1_sel = CCH_F6M50; end
    endcase
  end

  // bit rate with the slow and fast carrier overrides
  assign fa_sel   = carrier_reg ? f1_sel : f0_sel;
  assign rate_sel = (fa_sel == CCH_F1M75) ? CCH_R9K6 :
                    ((fa_sel == CCH_F10M50 || fa_sel == CCH_F13M00)
                     && rate_code == `CCH_RATE_9K6) ? CCH_R115K2 :
                    cch_rate_t'({1'b0, rate_code});

  // selection, hop and edge state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carrier_reg <= 1'b0;
      flip_reg    <= 1'b0;
      hop_reg     <= CCH_HOP_IDLE;
      noise_reg   <= 1'b0;
      wake_reg    <= 1'b0;
      pair_reg    <= `CCH_PAIR_RST;
    end else begin
      carrier_reg <= carrier_next;
      flip_reg    <= flip_next;
      hop_reg     <= hop_next;
      noise_reg   <= noise_detect;
      wake_reg    <= wake_in;
      pair_reg    <= pair_select;
    end
  end

  // wake edges before the first clock after reset are not counted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) wake_seen_reg <= 1'b0;
    else     wake_seen_reg <= 1'b1;
  end

  // low power and wake broadcast; a wake edge beats a sleep request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_reg <= 1'b0;
      bcast_reg <= 1'b0;
    end else begin
      sleep_reg <= (wake_edge && wake_seen_reg) ? 1'b0 :
                   (sleep_request ? 1'b1 : sleep_reg);
      bcast_reg <= wake_edge && wake_seen_reg;
    end
  end

  // registered status outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_reg   <= 1'b0;
      rx_reg   <= 1'b0;
      f0_reg   <= CCH_F5M50;
      f1_reg   <= CCH_F6M50;
      fa_reg   <= CCH_F5M50;
      rate_reg <= CCH_R19K2;
    end else begin
      tx_reg   <= tx_busy;
      rx_reg   <= !tx_busy && !sleep_reg;
      f0_reg   <= f0_sel;
      f1_reg   <= f1_sel;
      fa_reg   <= fa_sel;
      rate_reg <= rate_sel;
    end
  end

  assign active_carrier_indicator = carrier_reg;
  assign sending_active_out       = tx_reg;
  assign listening_active_out     = rx_reg;
  assign interference_status      = noise_reg;
  assign carrier_ready            = !lock_t.busy;
  assign first_carrier            = f0_reg;
  assign second_carrier           = f1_reg;
  assign active_freq              = fa_reg;
  assign bit_rate                 = rate_reg;
  assign low_power                = sleep_reg;
  assign wake_broadcast           = bcast_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  hop_toggle_a: assert property (hop_reg == CCH_HOP_IDLE && noise_rise
      && hop_on_noise_enable |=> flip_reg != $past(flip_reg)
      && hop_reg == CCH_HOP_NEW) else $error("hop did not toggle");
  hop_return_a: assert property (hop_reg == CCH_HOP_NEW && hop_t.done
      && !rx_byte_event && hop_on_noise_enable
      |=> flip_reg != $past(flip_reg) && hop_reg == CCH_HOP_BACK)
      else $error("no return after silent hop");
  hop_stay_a: assert property (hop_reg == CCH_HOP_BACK && hop_t.done
      && !rx_byte_event && !noise_detect && hop_on_noise_enable
      |=> flip_reg != $past(flip_reg) ##1 hop_reg == CCH_HOP_IDLE)
      else $error("no final hop");
  hop_timer_a: assert property (hop_reg == CCH_HOP_NEW
      |-> hop_t.busy || hop_t.done) else $error("hop timer idle in hop");
  sel_combine_a: assert property (1'b1 |=>
      active_carrier_indicator == ($past(sel_or) ^ flip_reg))
      else $error("carrier selection wrong");
  lock_wait_a: assert property (carrier_change |=> !carrier_ready
      [*8]) else $error("ready during lock wait");
  wake_edge_a: assert property (wake_edge && wake_seen_reg
      |=> wake_broadcast && !low_power ##1 !wake_broadcast)
      else $error("wake edge lost");
  slow_rate_a: assert property (fa_sel == CCH_F1M75
      |=> bit_rate == CCH_R9K6) else $error("slow carrier rate wrong");
  fast_rate_a: assert property ((fa_sel == CCH_F13M00
      || fa_sel == CCH_F10M50) && rate_code == `CCH_RATE_9K6
      |=> bit_rate == CCH_R115K2) else $error("fast carrier rate wrong");
  noise_status_a: assert property (1'b1 |=>
      interference_status == $past(noise_detect))
      else $error("interference status stale");
  tx_rx_excl_a: assert property (tx_busy |=> sending_active_out
      && !listening_active_out) else $error("send and listen overlap");

  hop_back_c:  cover property (hop_reg == CCH_HOP_BACK ##1
                               hop_reg == CCH_HOP_HOLD);
  lock_done_c: cover property (!carrier_ready ##1 carrier_ready);
  wake_c:      cover property (low_power ##1 wake_broadcast);
  hop_cancel_c: cover property (hop_reg == CCH_HOP_NEW && rx_byte_event
                                ##1 hop_reg == CCH_HOP_IDLE);

endmodule

// ### cch_host_model.sv
// host and modem side pin driver for the carrier channel hop control block
// assumes the bench calls its tasks; every pin moves on the falling edge
`timescale 1ns/1ps
module cch_host_model (
  input  wire logic  clk,
  output logic       carrier_select_in,
  output logic       carrier_select_bit,
  output logic       hop_on_noise_enable,
  output logic [3:0] pair_select,
  output logic [1:0] rate_code,
  output logic       noise_detect,
  output logic       rx_byte_event,
  output logic       tx_busy,
  output logic       sleep_request,
  output logic       wake_in
);
  // power-up levels: default pair so no lock wait starts at reset release
  initial begin
    {carrier_select_in, carrier_select_bit, hop_on_noise_enable} = 3'h0;
    pair_select = 4'hF;
    rate_code = 2'h3;
    {noise_detect, rx_byte_event, tx_busy, sleep_request, wake_in} = 5'h00;
  end

  // configuration pins, held until the next call
  task automatic set_cfg(input logic si, input logic sb, input logic he,
                         input logic [3:0] p, input logic [1:0] rc);
    @(negedge clk);
    carrier_select_in = si;
    carrier_select_bit = sb;
    hop_on_noise_enable = he;
    pair_select = p;
    rate_code = rc;
  endtask

  // line status pins; a reception pulse lasts until the next call
  task automatic set_line(input logic n, input logic rx, input logic tx,
                          input logic sl, input logic wk);
    @(negedge clk);
    noise_detect = n;
    rx_byte_event = rx;
    tx_busy = tx;
    sleep_request = sl;
    wake_in = wk;
  endtask
endmodule

// ### cch_testbench.sv
// self-checking bench for the carrier channel hop control block
// assumes short lock and hop counts: one tick is five clocks
`timescale 1ns/1ps
module testbench
  import cch_pkg::*;
;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        carrier_select_in, carrier_select_bit, hop_on_noise_enable;
  logic        noise_detect, rx_byte_event, tx_busy, sleep_request, wake_in;
  logic [3:0]  pair_select;
  logic [1:0]  rate_code;
  logic        active_carrier_indicator, sending_active_out;
  logic        listening_active_out, interference_status, carrier_ready;
  logic        low_power, wake_broadcast;
  cch_freq_t   first_carrier, second_carrier, active_freq;
  cch_rate_t   bit_rate;
  int          errors;
  int          compares;
  logic [31:0] lfsr;
  logic [7:0]  r;
  logic [3:0]  pr;
  logic        ind;
  string       f0_tab = "0000111152233442";
  string       f1_tab = "1234234565656564";

  // 20 MHz clock
  always #25 clk = ~clk;

  cch_host_model cch_host_model_i (.clk, .carrier_select_in,
    .carrier_select_bit, .hop_on_noise_enable, .pair_select, .rate_code,
    .noise_detect, .rx_byte_event, .tx_busy, .sleep_request, .wake_in);

  // small counts keep the two-second hop wait short in simulation
  cch_top #(.LOCK_TICKS(4), .HOP_TICKS(10)) cch_top_i (.clk, .rst,
    .carrier_select_in, .carrier_select_bit, .hop_on_noise_enable,
    .pair_select, .rate_code, .noise_detect, .rx_byte_event, .tx_busy,
    .sleep_request, .wake_in, .active_carrier_indicator,
    .sending_active_out, .listening_active_out, .interference_status,
    .carrier_ready, .first_carrier, .second_carrier, .active_freq,
    .bit_rate, .low_power, .wake_broadcast);

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // pair table as digit strings, one digit per pair index
  function automatic cch_freq_t pair_freq(input logic [3:0] p, input logic h);
    return cch_freq_t'(3'(h ? f1_tab[p] - 8'h30 : f0_tab[p] - 8'h30));
  endfunction

  function automatic cch_rate_t exp_rate(input cch_freq_t f,
                                         input logic [1:0] c);
    if (f == CCH_F1M75)
      return CCH_R9K6;
    if (c == 2'h2 && (f == CCH_F10M50 || f == CCH_F13M00))
      return CCH_R115K2;
    return cch_rate_t'({1'h0, c});
  endfunction

  task automatic fail(input string what);
    errors++;
    $display("[FAIL] %0t %s", $time, what);
  endtask

  task automatic check_bit(input logic got, input logic exp, input string w);
    compares++;
    if (got !== exp)
      fail(w);
  endtask

  task automatic check_freq(input cch_freq_t got, input cch_freq_t exp,
                            input string w);
    compares++;
    if (got !== exp)
      fail(w);
  endtask

  task automatic check_rate(input cch_rate_t got, input cch_rate_t exp,
                            input string w);
    compares++;
    if (got !== exp)
      fail(w);
  endtask

  task automatic complete_run;
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // bounded wait on the indicator or the ready flag, length checked too
  task automatic wait_for(input logic rdy, input logic val, input int lo,
                          input int hi);
    int n;
    n = 0;
    while ((rdy ? carrier_ready : active_carrier_indicator) !== val
           && n <= hi) begin
      @(negedge clk);
      n++;
    end
    check_bit(n >= lo && n <= hi, 1'h1, "wait length out of range");
    if (n > hi)
      complete_run();
  endtask

  task automatic check_cfg(input logic [1:0] rc);
    cch_freq_t f;
    f = pair_freq(pr, ind);
    check_bit(active_carrier_indicator, ind, "indicator");
    check_freq(first_carrier, pair_freq(pr, 0), "first");
    check_freq(second_carrier, pair_freq(pr, 1), "second");
    check_freq(active_freq, f, "active carrier");
    check_rate(bit_rate, exp_rate(f, rc), "bit rate");
  endtask

  initial begin
    errors = 0;
    compares = 0;
    lfsr = 32'h0000_0020;
    repeat (2) @(negedge clk);
    check_bit(active_carrier_indicator, 0, "reset indicator");
    check_bit(carrier_ready, 1, "reset ready");
    check_freq(first_carrier, CCH_F5M50, "reset first");
    check_freq(second_carrier, CCH_F6M50, "reset second");
    check_rate(bit_rate, CCH_R19K2, "reset rate");
    rst = 1'h0;
    ind = 1'h0;
    pr = 4'hF;
    // random selections; the first three are the rate override corners
    for (int i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      r = (i == 0) ? 8'h00 : (i == 1) ? 8'hA0 : (i == 2) ? 8'hBB : lfsr[7:0];
      cch_host_model_i.set_cfg(r[0], r[1], 0, r[5:2], r[7:6]);
      if ((r[0] | r[1]) != ind || r[5:2] != pr) begin
        wait_for(1, 0, 0, 3);
        wait_for(1, 1, 15, 30);
      end else begin
        repeat (3) @(negedge clk);
      end
      ind = r[0] | r[1];
      pr = r[5:2];
      check_cfg(r[7:6]);
    end
    // status pins follow the line; no hop while hopping is off
    for (int v = 1; v >= 0; v--) begin
      cch_host_model_i.set_line(v[0], 0, v[0], 0, 0);
      @(negedge clk);
      check_bit(interference_status, v[0], "interference");
      check_bit(sending_active_out, v[0], "sending");
      check_bit(listening_active_out, ~v[0], "listening");
      check_bit(active_carrier_indicator, ind, "hop while off");
    end
    // wake on a rising edge, then on a falling edge
    for (int w = 1; w >= 0; w--) begin
      cch_host_model_i.set_line(0, 0, 0, 1, ~w[0]);
      @(negedge clk);
      check_bit(low_power, 1, "sleep entry");
      cch_host_model_i.set_line(0, 0, 0, 0, w[0]);
      @(negedge clk);
      check_bit(wake_broadcast, 1, "wake pulse");
      check_bit(listening_active_out, 0, "listening asleep");
      check_bit(low_power, 0, "wake exit");
      @(negedge clk);
      check_bit(wake_broadcast, 0, "wake pulse end");
    end
    // hop cancelled by reception, then hop, return and final hop
    cch_host_model_i.set_cfg(r[0], r[1], 1, pr, r[7:6]);
    cch_host_model_i.set_line(1, 0, 0, 0, 0);
    wait_for(0, ~ind, 0, 3);
    cch_host_model_i.set_line(1, 1, 0, 0, 0);
    cch_host_model_i.set_line(0, 0, 0, 0, 0);
    repeat (70) @(negedge clk);
    check_bit(active_carrier_indicator, ~ind, "kept after reception");
    ind = ~ind;
    cch_host_model_i.set_line(1, 0, 0, 0, 0);
    wait_for(0, ~ind, 0, 3);
    wait_for(0, ind, 40, 60);
    cch_host_model_i.set_line(0, 0, 0, 0, 0);
    wait_for(0, ~ind, 40, 60);
    repeat (70) @(negedge clk);
    check_bit(active_carrier_indicator, ~ind, "stays after hop");
    // noise still present at the second expiry: stay, hop at the next expiry after it clears
    ind = ~ind;
    cch_host_model_i.set_line(1, 0, 0, 0, 0);
    wait_for(0, ~ind, 0, 3);
    wait_for(0, ind, 40, 60);
    repeat (70) @(negedge clk);
    check_bit(active_carrier_indicator, ind, "hop while noisy");
    cch_host_model_i.set_line(0, 0, 0, 0, 0);
    wait_for(0, ~ind, 20, 35);
    complete_run();
  end
endmodule
